// ### hw/rcs_pkg.sv
// Constants, command codes and types shared by the command strobe decoder and its bench.
package rcs_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_PERIOD_NS = 40;
    // Nominal internal reset pulse width; the allowed band is 240000 to 1000000 ns.
    localparam int RESET_TYP_NS = 650000;
    localparam int RESET_CYCLES = (RESET_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 16;
    localparam int RX_TICK_DIV = 1210;
    localparam int RCO_HZ = 34700;
    localparam int RCO_DIV = CLK_HZ / RCO_HZ;
    localparam logic [10:0] RX_DIV_LAST = 11'(RX_TICK_DIV - 1);
    localparam logic [9:0] RCO_DIV_LAST = 10'(RCO_DIV - 1);

    localparam logic [7:0] HDR_WRITE = 8'h00;
    localparam logic [7:0] HDR_READ = 8'h01;
    localparam logic [7:0] HDR_CMD = 8'h80;

    localparam logic [7:0] CMD_TX = 8'h60;
    localparam logic [7:0] CMD_RX = 8'h61;
    localparam logic [7:0] CMD_READY = 8'h62;
    localparam logic [7:0] CMD_STANDBY = 8'h63;
    localparam logic [7:0] CMD_SLEEP = 8'h64;
    localparam logic [7:0] CMD_LOCK_RX = 8'h65;
    localparam logic [7:0] CMD_LOCK_TX = 8'h66;
    localparam logic [7:0] CMD_ABORT = 8'h67;
    localparam logic [7:0] CMD_LDC_RELOAD = 8'h68;
    localparam logic [7:0] CMD_SEQ_RELOAD = 8'h69;
    localparam logic [7:0] CMD_ENCRYPT = 8'h6a;
    localparam logic [7:0] CMD_DERIVE_KEY = 8'h6b;
    localparam logic [7:0] CMD_DECRYPT = 8'h6c;
    localparam logic [7:0] CMD_DERIVE_DECRYPT = 8'h6d;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h70;
    localparam logic [7:0] CMD_RX_FLUSH = 8'h71;
    localparam logic [7:0] CMD_TX_FLUSH = 8'h72;

    localparam logic [7:0] ADDR_RX_PRESCALE = 8'h00;
    localparam logic [7:0] ADDR_RX_COUNT = 8'h01;
    localparam logic [7:0] ADDR_WU_PRESCALE = 8'h02;
    localparam logic [7:0] ADDR_WU_COUNT = 8'h03;
    localparam logic [7:0] ADDR_STATE = 8'h04;

    localparam logic [7:0] RST_RX_PRESCALE = 8'h01;
    localparam logic [7:0] RST_RX_COUNT = 8'h00;
    localparam logic [7:0] RST_WU_PRESCALE = 8'h01;
    localparam logic [7:0] RST_WU_COUNT = 8'h01;

    localparam logic [6:0] CODE_STANDBY = 7'h40;
    localparam logic [6:0] CODE_SLEEP = 7'h36;
    localparam logic [6:0] CODE_READY = 7'h03;
    localparam logic [6:0] CODE_LOCK = 7'h0f;
    localparam logic [6:0] CODE_RX = 7'h33;
    localparam logic [6:0] CODE_TX = 7'h5f;

    localparam int NUM_PULSE = 10;
    localparam int PL_SEQ = 0;
    localparam int PL_ENC = 1;
    localparam int PL_KEY = 2;
    localparam int PL_DEC = 3;
    localparam int PL_KEYDEC = 4;
    localparam int PL_RXFL = 5;
    localparam int PL_TXFL = 6;
    localparam int PL_LOW_DUTY_CYCLE_RELOAD = 7;
    localparam int PL_RXTO = 8;
    localparam int PL_WAKE = 9;

    typedef enum logic [2:0] {RCS_READY, RCS_TX, RCS_RX, RCS_STANDBY, RCS_SLEEP, RCS_LOCK} rcs_state_e;
endpackage

// ### hw/rcs_timer.sv
// Prescaler and counter timer that expires after (prescale+1)*(count+1) ticks.
`timescale 1ns/1ps
module rcs_timer (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_run,
    input wire logic i_zero_infinite,
    input wire logic [7:0] i_prescale,
    input wire logic [7:0] i_count,
    output logic o_expire
);
    logic [7:0] pre_r;
    logic [7:0] pre_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic exp_r;
    logic exp_nxt;
    logic frozen;

    assign frozen = i_zero_infinite && (i_prescale == 8'h00 || i_count == 8'h00);

    always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (i_start) begin
            pre_nxt = i_prescale;
            cnt_nxt = i_count;
        end else if (i_run && i_tick && !frozen) begin
            if (pre_r != 8'h00) begin
                pre_nxt = pre_r - 8'h01;
            end else if (cnt_r != 8'h00) begin
                pre_nxt = i_prescale;
                cnt_nxt = cnt_r - 8'h01;
            end else begin
                exp_nxt = 1'b1;
                pre_nxt = i_prescale;
                cnt_nxt = i_count;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pre_r <= 8'h00;
            cnt_r <= 8'h00;
            exp_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign o_expire = exp_r;

    property p_zero_infinite;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_zero_infinite && (i_prescale == 8'h00 || i_count == 8'h00)) [*2] |-> !o_expire;
    endproperty
    a_zero_infinite: assert property (p_zero_infinite) else $error("Timer expired with a zero setting.");

    property p_expire_cause;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_expire |-> $past(i_tick) && $past(i_run) && !$past(i_start);
    endproperty
    a_expire_cause: assert property (p_expire_cause) else $error("Timer expired without a running tick.");
endmodule

// ### hw/rcs_strobe.sv
// Command strobe decoder with register access, reset pulse generator and the two radio timers.
// Notes on behaviour
// - State strobes move TX/RX from ready, ready return, standby, sleep and abort.
// - Lock-for-receive from ready enters lock with receive synthesizer settings.
// - Lock-for-transmit from ready enters lock with transmit synthesizer settings.
// - Reload command restarts the wake-up timer from its prescale and count registers.
// - Sequence reload strobe, accepted in every state, reloads the packet counter.
// - Encrypt strobe, accepted in every state, starts the block cipher.
// - Key derivation strobe, accepted in every state, computes the decryption key.
// - Decrypt strobe, accepted in every state, decrypts with the current key.
// - Combined strobe derives the key and then decrypts, in every state.
// - Soft reset strobe starts the same internal reset as power-on.
// - A command acts as soon as its second byte completes, without chip select release.
// - Internal reset low lasts the pulse width after power-on or shutdown release.
// - Every register returns to its default while internal reset is low.
// - Timer period is (prescaler+1) times (counter+1) times the tick period.
// - Both prescaler and counter count one more than their value.
// - Receive timeout ticks every 1210 system clocks.
// - Zero receive timeout prescaler or counter means the timeout never expires.
// - Commands are header 0x80 then code; more accesses may follow in one frame.
// - Wake-up timer ticks at the internal RC oscillator rate.
`timescale 1ns/1ps
module rcs_strobe #(
    parameter int RESET_CYCLES_P = rcs_pkg::RESET_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_shutdown_input,
    input wire logic i_spi_sclk,
    input wire logic i_spi_csn,
    input wire logic i_spi_mosi,
    input wire logic i_tx_done,
    input wire logic i_rx_done,
    output logic o_spi_miso,
    output logic o_spi_miso_oe_n,
    output logic o_internal_reset_low,
    output logic [6:0] o_radio_state,
    output logic o_lock_for_transmit,
    output logic o_seq_reload,
    output logic o_cipher_encrypt,
    output logic o_cipher_derive_key,
    output logic o_cipher_decrypt,
    output logic o_cipher_derive_and_decrypt,
    output logic o_receive_fifo_flush,
    output logic o_transmit_fifo_flush,
    output logic o_low_duty_cycle_reload,
    output logic o_rx_timeout,
    output logic o_wakeup
);
    import rcs_pkg::*;

    function automatic logic [6:0] state_code(input rcs_state_e s);
        logic [6:0] c;
        c = CODE_READY;
        unique case (s)
            RCS_READY: c = CODE_READY;
            RCS_TX: c = CODE_TX;
            RCS_RX: c = CODE_RX;
            RCS_STANDBY: c = CODE_STANDBY;
            RCS_SLEEP: c = CODE_SLEEP;
            RCS_LOCK: c = CODE_LOCK;
            default: c = CODE_READY;
        endcase
        return c;
    endfunction

    // Pin synchronisers; only the second stage and later feed any logic.
    logic [1:0] shdn_s_r;
    logic [1:0] csn_s_r;
    logic [1:0] mosi_s_r;
    logic [2:0] sclk_s_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            shdn_s_r <= 2'h0;
            csn_s_r <= 2'h3;
            mosi_s_r <= 2'h0;
            sclk_s_r <= 3'h0;
        end else begin
            shdn_s_r <= {shdn_s_r[0], i_shutdown_input};
            csn_s_r <= {csn_s_r[0], i_spi_csn};
            mosi_s_r <= {mosi_s_r[0], i_spi_mosi};
            sclk_s_r <= {sclk_s_r[1:0], i_spi_sclk};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic csn_hi;
    assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
    assign sclk_fall = !sclk_s_r[1] && sclk_s_r[2];
    assign csn_hi = csn_s_r[1];

    // Reset pulse generator.
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic [RST_CNT_W-1:0] rst_cnt_nxt;
    logic rstn_r;
    logic clr;
    logic cmd_valid;
    logic [7:0] cmd_code;
    assign clr = i_sys_rst || (rst_cnt_r != '0);

    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        // Held while shut down, pulse after release.
        if (shdn_s_r[1]) begin
            rst_cnt_nxt = RST_CNT_W'(RESET_CYCLES_P);
        end else if (cmd_valid && cmd_code == CMD_SOFT_RESET) begin
            rst_cnt_nxt = RST_CNT_W'(RESET_CYCLES_P);
        end else if (rst_cnt_r != '0) begin
            rst_cnt_nxt = rst_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rst_cnt_r <= RST_CNT_W'(RESET_CYCLES_P);
            rstn_r <= 1'b0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            rstn_r <= (rst_cnt_nxt == '0);
        end
    end
    assign o_internal_reset_low = rstn_r;

    // Register file and SPI slave. SCLK must stay below an eighth of the system clock.
    logic [7:0] rx_pre_r, rx_pre_nxt, rx_cnt_r, rx_cnt_nxt;
    logic [7:0] wu_pre_r, wu_pre_nxt, wu_cnt_r, wu_cnt_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [7:0] sh_r, sh_nxt, hdr_r, hdr_nxt, addr_r, addr_nxt, miso_sh_r, miso_sh_nxt;
    logic miso_r, miso_nxt;
    logic [7:0] byte_in;
    rcs_state_e state_r, state_nxt;

    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_RX_PRESCALE: d = rx_pre_r;
            ADDR_RX_COUNT: d = rx_cnt_r;
            ADDR_WU_PRESCALE: d = wu_pre_r;
            ADDR_WU_COUNT: d = wu_cnt_r;
            ADDR_STATE: d = {1'b0, state_code(state_r)};
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    assign byte_in = {sh_r[6:0], mosi_s_r[1]};
    assign cmd_valid = !csn_hi && sclk_rise && bit_r == 3'h7 && idx_r == 2'h1 && hdr_r == HDR_CMD;
    assign cmd_code = byte_in;

    always_comb begin
        {rx_pre_nxt, rx_cnt_nxt, wu_pre_nxt, wu_cnt_nxt} = {rx_pre_r, rx_cnt_r, wu_pre_r, wu_cnt_r};
        {bit_nxt, idx_nxt, sh_nxt, hdr_nxt, addr_nxt} = {bit_r, idx_r, sh_r, hdr_r, addr_r};
        miso_sh_nxt = miso_sh_r;
        miso_nxt = miso_r;
        if (csn_hi) begin
            bit_nxt = 3'h0;
            idx_nxt = 2'h0;
        end else if (sclk_rise) begin
            sh_nxt = byte_in;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                if (idx_r == 2'h0) begin
                    hdr_nxt = byte_in;
                    idx_nxt = 2'h1;
                end else if (idx_r == 2'h1 && hdr_r == HDR_CMD) begin
                    idx_nxt = 2'h0;
                end else if (idx_r == 2'h1) begin
                    addr_nxt = byte_in;
                    idx_nxt = 2'h2;
                    miso_sh_nxt = rd_reg(byte_in);
                end else begin
                    addr_nxt = addr_r + 8'h01;
                    miso_sh_nxt = rd_reg(addr_r + 8'h01);
                    if (hdr_r == HDR_WRITE) begin
                        if (addr_r == ADDR_RX_PRESCALE) rx_pre_nxt = byte_in;
                        if (addr_r == ADDR_RX_COUNT) rx_cnt_nxt = byte_in;
                        if (addr_r == ADDR_WU_PRESCALE) wu_pre_nxt = byte_in;
                        if (addr_r == ADDR_WU_COUNT) wu_cnt_nxt = byte_in;
                    end
                end
            end
        end else if (sclk_fall && hdr_r == HDR_READ && idx_r == 2'h2) begin
            miso_nxt = miso_sh_r[7];
            miso_sh_nxt = {miso_sh_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr) begin
            rx_pre_r <= RST_RX_PRESCALE;
            rx_cnt_r <= RST_RX_COUNT;
            wu_pre_r <= RST_WU_PRESCALE;
            wu_cnt_r <= RST_WU_COUNT;
            {bit_r, idx_r, sh_r, hdr_r, addr_r, miso_sh_r} <= '0;
            miso_r <= 1'b0;
        end else begin
            {rx_pre_r, rx_cnt_r, wu_pre_r, wu_cnt_r} <= {rx_pre_nxt, rx_cnt_nxt, wu_pre_nxt, wu_cnt_nxt};
            {bit_r, idx_r, sh_r, hdr_r, addr_r} <= {bit_nxt, idx_nxt, sh_nxt, hdr_nxt, addr_nxt};
            miso_sh_r <= miso_sh_nxt;
            miso_r <= miso_nxt;
        end
    end
    assign o_spi_miso = miso_r;
    assign o_spi_miso_oe_n = csn_hi || clr;

    // Radio control state, command strobes and tick dividers.
    logic lock_tx_r, lock_tx_nxt;
    logic [NUM_PULSE-1:0] pulse_r, pulse_nxt;
    logic [10:0] rx_div_r, rx_div_nxt;
    logic [9:0] rco_div_r, rco_div_nxt;
    logic rx_tick, rco_tick, rx_exp, wu_exp, rx_start, wu_start;

    assign rx_tick = rx_div_r == RX_DIV_LAST;
    assign rco_tick = rco_div_r == RCO_DIV_LAST;

    always_comb begin
        state_nxt = state_r;
        lock_tx_nxt = lock_tx_r;
        pulse_nxt = '0;
        rx_div_nxt = rx_tick ? 11'h000 : rx_div_r + 11'h001;
        rco_div_nxt = rco_tick ? 10'h000 : rco_div_r + 10'h001;
        if (state_r == RCS_TX && i_tx_done) state_nxt = RCS_READY;
        if (state_r == RCS_RX && (i_rx_done || rx_exp)) state_nxt = RCS_READY;
        pulse_nxt[PL_RXTO] = state_r == RCS_RX && rx_exp;
        if (state_r == RCS_SLEEP && wu_exp) state_nxt = RCS_READY;
        pulse_nxt[PL_WAKE] = state_r == RCS_SLEEP && wu_exp;
        if (cmd_valid) begin
            case (cmd_code)
                CMD_TX: if (state_r == RCS_READY) state_nxt = RCS_TX;
                CMD_RX: if (state_r == RCS_READY) state_nxt = RCS_RX;
                CMD_READY: if (state_r inside {RCS_STANDBY, RCS_SLEEP, RCS_LOCK}) state_nxt = RCS_READY;
                CMD_STANDBY: if (state_r == RCS_READY) state_nxt = RCS_STANDBY;
                CMD_SLEEP: if (state_r == RCS_READY) state_nxt = RCS_SLEEP;
                CMD_ABORT: if (state_r inside {RCS_TX, RCS_RX}) state_nxt = RCS_READY;
                CMD_LOCK_RX: if (state_r == RCS_READY) state_nxt = RCS_LOCK;
                CMD_LOCK_TX: if (state_r == RCS_READY) state_nxt = RCS_LOCK;
                CMD_LDC_RELOAD: pulse_nxt[PL_LOW_DUTY_CYCLE_RELOAD] = 1'b1;
                CMD_SEQ_RELOAD: pulse_nxt[PL_SEQ] = 1'b1;
                CMD_ENCRYPT: pulse_nxt[PL_ENC] = 1'b1;
                CMD_DERIVE_KEY: pulse_nxt[PL_KEY] = 1'b1;
                CMD_DECRYPT: pulse_nxt[PL_DEC] = 1'b1;
                CMD_DERIVE_DECRYPT: pulse_nxt[PL_KEYDEC] = 1'b1;
                CMD_RX_FLUSH: pulse_nxt[PL_RXFL] = 1'b1;
                CMD_TX_FLUSH: pulse_nxt[PL_TXFL] = 1'b1;
                default: ;
            endcase
            if (state_r == RCS_READY && cmd_code inside {CMD_LOCK_RX, CMD_LOCK_TX}) begin
                lock_tx_nxt = cmd_code == CMD_LOCK_TX;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (clr) begin
            state_r <= RCS_READY;
            lock_tx_r <= 1'b0;
            pulse_r <= '0;
            rx_div_r <= 11'h000;
            rco_div_r <= 10'h000;
        end else begin
            state_r <= state_nxt;
            lock_tx_r <= lock_tx_nxt;
            pulse_r <= pulse_nxt;
            rx_div_r <= rx_div_nxt;
            rco_div_r <= rco_div_nxt;
        end
    end

    assign rx_start = state_nxt == RCS_RX && state_r != RCS_RX;
    // Reload or sleep entry restarts the wake-up count.
    assign wu_start = (state_nxt == RCS_SLEEP && state_r != RCS_SLEEP) || pulse_nxt[PL_LOW_DUTY_CYCLE_RELOAD];

    rcs_timer u_rx_timer (
        .i_clk(i_clk),
        .i_sys_rst(clr),
        .i_tick(rx_tick),
        .i_start(rx_start),
        .i_run(state_r == RCS_RX),
        .i_zero_infinite(1'b1),
        .i_prescale(rx_pre_r),
        .i_count(rx_cnt_r),
        .o_expire(rx_exp)
    );

    // The host keeps the wake-up values non-zero, so no infinite case is needed here.
    rcs_timer u_wu_timer (
        .i_clk(i_clk),
        .i_sys_rst(clr),
        .i_tick(rco_tick),
        .i_start(wu_start),
        .i_run(state_r == RCS_SLEEP),
        .i_zero_infinite(1'b0),
        .i_prescale(wu_pre_r),
        .i_count(wu_cnt_r),
        .o_expire(wu_exp)
    );

    assign o_radio_state = state_code(state_r);
    assign o_lock_for_transmit = lock_tx_r;
    assign o_seq_reload = pulse_r[PL_SEQ];
    assign o_cipher_encrypt = pulse_r[PL_ENC];
    assign o_cipher_derive_key = pulse_r[PL_KEY];
    assign o_cipher_decrypt = pulse_r[PL_DEC];
    assign o_cipher_derive_and_decrypt = pulse_r[PL_KEYDEC];
    assign o_receive_fifo_flush = pulse_r[PL_RXFL];
    assign o_transmit_fifo_flush = pulse_r[PL_TXFL];
    assign o_low_duty_cycle_reload = pulse_r[PL_LOW_DUTY_CYCLE_RELOAD];
    assign o_rx_timeout = pulse_r[PL_RXTO];
    assign o_wakeup = pulse_r[PL_WAKE];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_tx_start;
        cmd_valid && cmd_code == CMD_TX && state_r == RCS_READY && !clr |=> o_radio_state == CODE_TX;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("Transmit strobe did not enter transmit.");

    property p_tx_refused;
        cmd_valid && cmd_code == CMD_TX && state_r == RCS_SLEEP && !wu_exp && !clr |=> state_r == RCS_SLEEP;
    endproperty
    a_tx_refused: assert property (p_tx_refused) else $error("Transmit strobe acted outside ready.");

    property p_lock_rx;
        cmd_valid && cmd_code == CMD_LOCK_RX && state_r == RCS_READY && !clr |=> state_r == RCS_LOCK && !o_lock_for_transmit;
    endproperty
    a_lock_rx: assert property (p_lock_rx) else $error("Receive lock strobe mishandled.");

    property p_lock_tx;
        cmd_valid && cmd_code == CMD_LOCK_TX && state_r == RCS_READY && !clr |=> state_r == RCS_LOCK && o_lock_for_transmit;
    endproperty
    a_lock_tx: assert property (p_lock_tx) else $error("Transmit lock strobe mishandled.");

    property p_seq_pulse;
        cmd_valid && cmd_code == CMD_SEQ_RELOAD && !clr |=> o_seq_reload ##1 !o_seq_reload;
    endproperty
    a_seq_pulse: assert property (p_seq_pulse) else $error("Sequence reload pulse wrong.");

    property p_keydec_pulse;
        cmd_valid && cmd_code == CMD_DERIVE_DECRYPT && !clr |=> o_cipher_derive_and_decrypt && !o_cipher_decrypt;
    endproperty
    a_keydec_pulse: assert property (p_keydec_pulse) else $error("Combined cipher strobe wrong.");

    property p_flush_pulse;
        cmd_valid && cmd_code == CMD_RX_FLUSH && !clr |=> o_receive_fifo_flush && !o_transmit_fifo_flush;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse) else $error("Receive flush strobe wrong.");

    property p_soft_reset;
        cmd_valid && cmd_code == CMD_SOFT_RESET |=> !o_internal_reset_low [*8] ##1 state_r == RCS_READY;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset did not hold reset low.");

    property p_reset_regs;
        !o_internal_reset_low |=> rx_cnt_r == RST_RX_COUNT && wu_pre_r == RST_WU_PRESCALE;
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("Register not at default during reset.");

    property p_rx_timeout;
        o_rx_timeout |-> $past(state_r) == RCS_RX && state_r == RCS_READY && rx_cnt_r != 8'h00;
    endproperty
    a_rx_timeout: assert property (p_rx_timeout) else $error("Receive timeout fired wrongly.");
endmodule

// ### bench/rcs_spi_host.sv
// SPI master model standing in for the host controller.
`timescale 1ns/1ps
module rcs_spi_host (
    input wire logic i_clk,
    input wire logic i_spi_miso,
    output logic o_spi_sclk,
    output logic o_spi_csn,
    output logic o_spi_mosi
);
    initial begin
        o_spi_sclk = 1'b0;
        o_spi_csn = 1'b1;
        o_spi_mosi = 1'b0;
    end
    // Six clocks a half period keeps SCLK well below clk/8.
    task automatic half();
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    task automatic sel(input logic on);
        half();
        o_spi_csn = !on;
        // Released data line shows the inverse of its last bit.
        if (!on) o_spi_mosi = !o_spi_mosi;
    endtask
    // One byte out and one byte in, MSB first.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_spi_mosi = tx[i];
            half();
            o_spi_sclk = 1'b1;
            rx[i] = i_spi_miso;
            half();
            o_spi_sclk = 1'b0;
        end
    endtask
endmodule

// ### bench/rcs_strobe_bench.sv
// Self-checking bench for the command strobe decoder.
`timescale 1ns/1ps
module rcs_strobe_bench;
    import rcs_pkg::*;
    typedef struct {logic [7:0] c; logic [6:0] s; logic [9:0] p;} rcs_row_s;
    logic clk, rst, shutdown_input, txd, rxd, sclk, csn, mosi, miso, oen, rstn, lk, clr;
    logic q0, q1, q2, q3, q4, q5, q6, q7, q8, q9;
    logic [6:0] st;
    logic [9:0] pl, seen;
    logic [7:0] rd;
    int fails, check_count, cyc, n;
    rcs_row_s rows [26];
    rcs_strobe #(.RESET_CYCLES_P(20)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_shutdown_input(shutdown_input),
        .i_spi_sclk(sclk), .i_spi_csn(csn), .i_spi_mosi(mosi), .i_tx_done(txd), .i_rx_done(rxd),
        .o_spi_miso(miso), .o_spi_miso_oe_n(oen), .o_internal_reset_low(rstn), .o_radio_state(st),
        .o_lock_for_transmit(lk), .o_seq_reload(q0), .o_cipher_encrypt(q1), .o_cipher_derive_key(q2),
        .o_cipher_decrypt(q3), .o_cipher_derive_and_decrypt(q4), .o_receive_fifo_flush(q5),
        .o_transmit_fifo_flush(q6), .o_low_duty_cycle_reload(q7), .o_rx_timeout(q8), .o_wakeup(q9));
    assign pl = {q9, q8, q7, q6, q5, q4, q3, q2, q1, q0};
    rcs_spi_host HOST (.i_clk(clk), .i_spi_miso(miso), .o_spi_sclk(sclk), .o_spi_csn(csn), .o_spi_mosi(mosi));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        seen <= (clr | rst) ? 10'h0 : seen | pl;
        cyc++;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Leaves chip select low so the effect is seen before release.
    task automatic cmd(input logic [7:0] c);
        @(posedge clk) #1 clr = 1'b1;
        @(posedge clk) #1 clr = 1'b0;
        HOST.sel(1);
        HOST.xfer(HDR_CMD, rd);
        HOST.xfer(c, rd);
        repeat (4) @(posedge clk);
    endtask
    task automatic reg_acc(input logic [7:0] h, input logic [7:0] a, input logic [7:0] d);
        HOST.sel(1);
        HOST.xfer(h, rd);
        HOST.xfer(a, rd);
        HOST.xfer(d, rd);
        HOST.sel(0);
    endtask
    task automatic wait_seen(input int b, input int lim);
        for (n = 0; !seen[b] && n < lim; n++) @(posedge clk) #1;
    endtask
    task automatic wait_rstn();
        for (n = 0; rstn !== 1'b1 && n < 200; n++) @(posedge clk) #1;
    endtask
    initial begin
        {rst, shutdown_input, txd, rxd, clr} = 5'h10;
        rows = '{'{8'h63, 7'h40, 10'h0}, '{8'h60, 7'h40, 10'h0}, '{8'h62, 7'h03, 10'h0}, '{8'h64, 7'h36, 10'h0},
            '{8'h60, 7'h36, 10'h0}, '{8'h68, 7'h36, 10'h080}, '{8'h62, 7'h03, 10'h0}, '{8'h65, 7'h0f, 10'h0},
            '{8'h62, 7'h03, 10'h0}, '{8'h66, 7'h0f, 10'h0}, '{8'h62, 7'h03, 10'h0}, '{8'h60, 7'h5f, 10'h0},
            '{8'h69, 7'h5f, 10'h001}, '{8'h67, 7'h03, 10'h0}, '{8'h61, 7'h33, 10'h0}, '{8'h6a, 7'h33, 10'h002},
            '{8'h67, 7'h03, 10'h0}, '{8'h6b, 7'h03, 10'h004}, '{8'h6c, 7'h03, 10'h008}, '{8'h6d, 7'h03, 10'h010},
            '{8'h71, 7'h03, 10'h020}, '{8'h72, 7'h03, 10'h040}, '{8'h5f, 7'h03, 10'h0}, '{8'h67, 7'h03, 10'h0},
            '{8'h63, 7'h40, 10'h0}, '{8'h62, 7'h03, 10'h0}};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        wait_rstn();
        chk(10'(n), 10'h014);
        reg_acc(HDR_READ, ADDR_RX_COUNT, 8'h00);
        chk(10'(rd), 10'(RST_RX_COUNT));
        reg_acc(HDR_READ, ADDR_RX_PRESCALE, 8'h00);
        chk(10'(rd), 10'(RST_RX_PRESCALE));
        foreach (rows[i]) begin
            cmd(rows[i].c);
            chk(10'(st), 10'(rows[i].s));
            chk(seen, rows[i].p);
            chk(10'(oen), 10'h000);
            if (rows[i].s == 7'h0f) chk(10'(lk), 10'(rows[i].c == CMD_LOCK_TX));
            HOST.sel(0);
        end
        $display("table done");
        cmd(CMD_TX);
        HOST.sel(0);
        @(posedge clk) #1 txd = 1'b1;
        @(posedge clk) #1 txd = 1'b0;
        @(posedge clk) #1 chk(10'(st), 10'(CODE_READY));
        chk(10'(oen), 10'h001);
        reg_acc(HDR_WRITE, ADDR_RX_COUNT, 8'h01);
        cmd(CMD_RX);
        HOST.sel(0);
        wait_seen(PL_RXTO, 8000);
        chk(10'(n > 3600 && n < 4870), 10'h001);
        chk(10'(st), 10'(CODE_READY));
        reg_acc(HDR_WRITE, ADDR_RX_COUNT, 8'h00);
        cmd(CMD_RX);
        HOST.sel(0);
        wait_seen(PL_RXTO, 6000);
        chk(10'(seen[PL_RXTO]), 10'h000);
        chk(10'(st), 10'(CODE_RX));
        cmd(CMD_ABORT);
        chk(10'(st), 10'(CODE_READY));
        HOST.sel(0);
        cmd(CMD_RX);
        HOST.sel(0);
        @(posedge clk) #1 rxd = 1'b1;
        @(posedge clk) #1 rxd = 1'b0;
        @(posedge clk) #1 chk(10'(st), 10'(CODE_READY));
        reg_acc(HDR_WRITE, ADDR_WU_PRESCALE, 8'h02);
        cmd(CMD_SLEEP);
        HOST.sel(0);
        wait_seen(PL_WAKE, 5000);
        chk(10'(n > 3500 && n < 4340), 10'h001);
        chk(10'(st), 10'(CODE_READY));
        $display("timers done");
        reg_acc(HDR_WRITE, ADDR_RX_COUNT, 8'h05);
        cmd(CMD_SOFT_RESET);
        chk(10'(rstn), 10'h000);
        chk(10'(oen), 10'h001);
        HOST.sel(0);
        wait_rstn();
        reg_acc(HDR_READ, ADDR_RX_COUNT, 8'h00);
        chk(10'(rd), 10'(RST_RX_COUNT));
        shutdown_input = 1'b1;
        repeat (5) @(posedge clk);
        #1 shutdown_input = 1'b0;
        chk(10'(rstn), 10'h000);
        chk(10'(oen), 10'h001);
        wait_rstn();
        chk(10'(n), 10'h016);
        $display("reset done");
        final_report();
    end
endmodule
